// ==== core/core_exec_pkg.sv ====
`default_nettype none
package core_exec_pkg;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 20;
    localparam logic [19:0] LOW_SPACE_LIMIT = 20'h10000;
    localparam logic [19:0] STACK_STEP = 20'h00002;
    localparam logic [19:0] PC_STEP = 20'h00002;
    localparam logic [19:0] INC_BYTE = 20'h00001;
    localparam logic [19:0] INC_WORD = 20'h00002;
    localparam logic [19:0] INC_AWORD = 20'h00004;
    localparam logic [19:0] RESET_PC = 20'h00000;
    localparam logic [19:0] RESET_SP = 20'h00000;
    // Instruction word fields
    localparam int JOP_HI = 15;
    localparam int JOP_LO = 13;
    localparam int JCOND_HI = 12;
    localparam int JCOND_LO = 10;
    localparam int JOFS_HI = 9;
    localparam int FMT1_HI = 15;
    localparam int FMT1_LO = 12;
    localparam int FMT2_HI = 9;
    localparam int FMT2_LO = 7;
    localparam int SRC_HI = 11;
    localparam int SRC_LO = 8;
    localparam int AD_BIT = 7;
    localparam int BW_BIT = 6;
    localparam int AS_HI = 5;
    localparam int AS_LO = 4;
    localparam int DST_HI = 3;
    localparam int DST_LO = 0;
    localparam logic [2:0] JUMP_OPCODE = 3'h1;
    localparam logic [5:0] FMT2_PREFIX = 6'h04;
    // Addressing modes of the two-bit source field
    localparam logic [1:0] AM_REG = 2'h0;
    localparam logic [1:0] AM_INDEXED = 2'h1;
    localparam logic [1:0] AM_INDIRECT = 2'h2;
    localparam logic [1:0] AM_AUTOINC = 2'h3;
    localparam logic [3:0] REG_PC = 4'h0;
    localparam logic [3:0] REG_SP = 4'h1;
    // Status register bit positions
    localparam int SR_C = 0;
    localparam int SR_Z = 1;
    localparam int SR_N = 2;
    localparam int SR_V = 8;
    typedef enum logic [3:0] {
        OP_MOV = 4'h4, OP_ADD = 4'h5, add_with_carry = 4'h6, OP_SUB = 4'h7,
        subtract_with_carry = 4'h8, OP_CMP = 4'h9, decimal_add = 4'ha, OP_BTEST = 4'hb,
        bit_clear_op = 4'hc, bit_set_op = 4'hd, OP_XOR = 4'he, OP_AND = 4'hf
    } two_op_t;
    typedef enum logic [2:0] {
        rotate_right_through_carry = 3'h0, byte_swap = 3'h1, arith_shift_right = 3'h2,
        sign_extend_op = 3'h3, OP_PUSH = 3'h4, OP_CALL = 3'h5, interrupt_return = 3'h6
    } one_op_t;
    typedef enum logic [2:0] {
        jump_if_not_equal = 3'h0, jump_if_equal = 3'h1, jump_if_no_carry = 3'h2,
        jump_if_carry = 3'h3, jump_if_negative = 3'h4, jump_signed_ge = 3'h5,
        jump_signed_lt = 3'h6, jump_always = 3'h7
    } jump_cond_t;
endpackage
`default_nettype wire

// ==== core/core_instruction_execute.sv ====
`default_nettype none
module core_instruction_execute
    import core_exec_pkg::*;
(
    input wire logic ref_clk, // 200 MHz clock
    input wire logic reset_n, // Async reset, active low
    input wire logic exec_valid, // Pulse: execute one instruction
    input wire logic [15:0] instr, // Opcode word
    input wire logic [19:0] src_val, // Source operand as fetched
    input wire logic [19:0] dst_val, // Destination operand as fetched
    input wire logic [19:0] stack_top, // Word at current stack address
    input wire logic [19:0] stack_next, // Word at stack address plus two
    input wire logic address_word, // Operation on 20-bit address words
    output logic done, // Pulse: results valid
    output logic [19:0] result, // Value to write to destination
    output logic result_write, // Result is to be stored
    output logic [15:0] status, // Status register
    output logic [19:0] pc, // Program counter
    output logic [19:0] sp, // Stack pointer
    output logic [19:0] src_reg_incr, // Amount added to source register
    output logic [1:0] extra_words, // Extension words this opcode needs
    output logic [19:0] push_addr, // Store address of a push
    output logic low_space_fault // Call or return outside the low space
);
    typedef struct packed {
        logic done;
        logic [19:0] result;
        logic result_write;
        logic [15:0] status;
        logic [19:0] pc;
        logic [19:0] sp;
        logic [19:0] src_reg_incr;
        logic [1:0] extra_words;
        logic [19:0] push_addr;
        logic low_space_fault;
    } state_t;

    state_t cur, next_cur;

    function automatic logic [19:0] bcd_add(input logic [19:0] a, input logic [19:0] b, input logic cin,
                                           input int digits, output logic cout);
        logic [19:0] sum;
        logic c;
        logic [4:0] d;
        sum = 20'h00000;
        c = cin;
        for (int i = 0; i < 5; i++) begin
            if (i < digits) begin
                d = {1'b0, a[i*4 +: 4]} + {1'b0, b[i*4 +: 4]} + {4'h0, c};
                if (d > 5'h09) begin
                    d = d + 5'h06;
                    c = 1'b1;
                end else begin
                    c = 1'b0;
                end
                sum[i*4 +: 4] = d[3:0];
            end
        end
        cout = c;
        return sum;
    endfunction

    logic [3:0] f1_op;
    logic [1:0] as_mode;
    logic ad_mode;
    logic byte_op;
    logic is_jump;
    logic is_fmt2;
    logic [3:0] src_reg;
    logic [3:0] dst_reg;
    assign f1_op = instr[FMT1_HI:FMT1_LO];
    assign as_mode = instr[AS_HI:AS_LO];
    assign ad_mode = instr[AD_BIT];
    assign byte_op = instr[BW_BIT];
    assign src_reg = instr[SRC_HI:SRC_LO];
    assign dst_reg = instr[DST_HI:DST_LO];
    assign is_jump = instr[JOP_HI:JOP_LO] == JUMP_OPCODE;
    assign is_fmt2 = instr[15:10] == FMT2_PREFIX;

    always_comb begin
        logic [19:0] mask;
        logic [19:0] msb;
        logic [19:0] s;
        logic [19:0] d;
        logic [20:0] wide;
        logic [19:0] r;
        logic cflag;
        logic vflag;
        logic keep_flags;
        logic set_nz;
        logic take;
        logic bcd_c;
        logic [19:0] ofs;
        int digits;
        mask = 20'h0ffff;
        msb = 20'h08000;
        s = 20'h00000;
        d = 20'h00000;
        wide = 21'h000000;
        r = 20'h00000;
        cflag = status[SR_C];
        vflag = status[SR_V];
        keep_flags = 1'b1;
        set_nz = 1'b0;
        take = 1'b0;
        bcd_c = 1'b0;
        ofs = 20'h00000;
        digits = 4;
        next_cur = cur;
        next_cur.done = 1'b0;
        if (exec_valid) begin
            next_cur.done = 1'b1;
            next_cur.result_write = 1'b0;
            next_cur.src_reg_incr = 20'h00000;
            next_cur.extra_words = 2'h0;
            next_cur.low_space_fault = 1'b0;
            if (address_word) begin
                mask = 20'hfffff;
                msb = 20'h80000;
                digits = 5;
            end else if (byte_op) begin
                mask = 20'h000ff;
                msb = 20'h00080;
                digits = 2;
            end
            s = src_val & mask;
            d = dst_val & mask;
            next_cur.pc = cur.pc + PC_STEP;
            if (is_jump) begin
                case (jump_cond_t'(instr[JCOND_HI:JCOND_LO]))
                    jump_if_equal: take = cur.status[SR_Z];
                    jump_if_not_equal: take = !cur.status[SR_Z];
                    jump_if_carry: take = cur.status[SR_C];
                    jump_if_no_carry: take = !cur.status[SR_C];
                    jump_if_negative: take = cur.status[SR_N];
                    jump_signed_ge: take = (cur.status[SR_N] ^ cur.status[SR_V]) == 1'b0;
                    jump_signed_lt: take = (cur.status[SR_N] ^ cur.status[SR_V]) == 1'b1;
                    jump_always: take = 1'b1;
                    default: take = 1'b0;
                endcase
                ofs = {{9{instr[JOFS_HI]}}, instr[JOFS_HI:0], 1'b0};
                if (take) begin
                    next_cur.pc = cur.pc + PC_STEP + ofs;
                end
            end else if (is_fmt2) begin
                // Extra destination word for indexed, symbolic, absolute or immediate
                next_cur.extra_words = (as_mode == AM_INDEXED || (as_mode == AM_AUTOINC && dst_reg == REG_PC))
                    ? 2'h1 : 2'h0;
                case (one_op_t'(instr[FMT2_HI:FMT2_LO]))
                    rotate_right_through_carry: begin
                        r = ((d >> 1) | (cur.status[SR_C] ? msb : 20'h00000)) & mask;
                        cflag = d[0];
                        vflag = 1'b0;
                        keep_flags = 1'b0;
                        set_nz = 1'b1;
                        next_cur.result_write = 1'b1;
                    end
                    arith_shift_right: begin
                        r = ((d >> 1) | (d & msb)) & mask;
                        cflag = d[0];
                        vflag = 1'b0;
                        keep_flags = 1'b0;
                        set_nz = 1'b1;
                        next_cur.result_write = 1'b1;
                    end
                    byte_swap: begin
                        r = {d[19:16], d[7:0], d[15:8]};
                        next_cur.result_write = 1'b1;
                    end
                    sign_extend_op: begin
                        r = (as_mode == AM_REG) ? {{12{d[7]}}, d[7:0]}
                                                : {d[19:16], {8{d[7]}}, d[7:0]};
                        mask = (as_mode == AM_REG) ? 20'hfffff : 20'h0ffff;
                        msb = (as_mode == AM_REG) ? 20'h80000 : 20'h08000;
                        vflag = 1'b0;
                        cflag = r[7:0] != 8'h00;
                        keep_flags = 1'b0;
                        set_nz = 1'b1;
                        next_cur.result_write = 1'b1;
                    end
                    OP_PUSH: begin
                        next_cur.sp = cur.sp - STACK_STEP;
                        next_cur.push_addr = cur.sp - STACK_STEP;
                        r = s;
                        next_cur.result_write = 1'b1;
                    end
                    OP_CALL: begin
                        next_cur.sp = cur.sp - STACK_STEP;
                        next_cur.push_addr = cur.sp - STACK_STEP;
                        r = cur.pc + PC_STEP;
                        next_cur.result_write = 1'b1;
                        next_cur.pc = d & 20'h0ffff;
                        next_cur.low_space_fault = cur.pc >= LOW_SPACE_LIMIT;
                    end
                    interrupt_return: begin
                        next_cur.status = stack_top[15:0];
                        next_cur.pc = stack_next;
                        next_cur.sp = cur.sp + STACK_STEP + STACK_STEP;
                    end
                    default: r = d;
                endcase
                if (as_mode == AM_AUTOINC && dst_reg != REG_PC) begin
                    next_cur.src_reg_incr = address_word ? INC_AWORD : (byte_op ? INC_BYTE : INC_WORD);
                end
            end else if (f1_op >= 4'h4) begin
                // Extra words for source and destination extended modes
                next_cur.extra_words = ((as_mode == AM_INDEXED || (as_mode == AM_AUTOINC && src_reg == REG_PC))
                    ? 2'h1 : 2'h0) + (ad_mode ? 2'h1 : 2'h0);
                if (as_mode == AM_AUTOINC && src_reg != REG_PC) begin
                    next_cur.src_reg_incr = address_word ? INC_AWORD : (byte_op ? INC_BYTE : INC_WORD);
                end
                next_cur.result_write = 1'b1;
                case (two_op_t'(f1_op))
                    OP_MOV: r = s;
                    OP_ADD, add_with_carry: begin
                        wide = {1'b0, d} + {1'b0, s} +
                               {20'h00000, (two_op_t'(f1_op) == add_with_carry) && cur.status[SR_C]};
                    end
                    OP_SUB, subtract_with_carry, OP_CMP: begin
                        wide = {1'b0, d} + {1'b0, ~s & mask} +
                               {20'h00000, (two_op_t'(f1_op) == subtract_with_carry) ? cur.status[SR_C] : 1'b1};
                        next_cur.result_write = two_op_t'(f1_op) != OP_CMP;
                    end
                    decimal_add: begin
                        r = bcd_add(d, s, cur.status[SR_C], digits, bcd_c) & mask;
                        cflag = bcd_c;
                        vflag = 1'b0;
                        keep_flags = 1'b0;
                        set_nz = 1'b1;
                    end
                    OP_BTEST, OP_AND: begin
                        r = s & d;
                        vflag = 1'b0;
                        cflag = r != 20'h00000;
                        keep_flags = 1'b0;
                        set_nz = 1'b1;
                        next_cur.result_write = two_op_t'(f1_op) == OP_AND;
                    end
                    bit_clear_op: r = ~s & d & mask;
                    bit_set_op: r = s | d;
                    OP_XOR: begin
                        r = s ^ d;
                        vflag = ((s & msb) != 20'h00000) && ((d & msb) != 20'h00000);
                        cflag = r != 20'h00000;
                        keep_flags = 1'b0;
                        set_nz = 1'b1;
                    end
                    default: r = d;
                endcase
                if (f1_op >= 4'h5 && f1_op <= 4'h9) begin
                    // Carry out taken from the bit just above the operand width
                    r = wide[19:0] & mask;
                    cflag = address_word ? wide[20] : (byte_op ? wide[8] : wide[16]);
                    vflag = ((f1_op >= 4'h7) ? ((d & msb) != (s & msb)) : ((d & msb) == (s & msb)))
                            && ((r & msb) != (d & msb));
                    keep_flags = 1'b0;
                    set_nz = 1'b1;
                end
                if (dst_reg == REG_PC && ad_mode == 1'b0 && next_cur.result_write) begin
                    next_cur.pc = r;
                    next_cur.result_write = 1'b0;
                    next_cur.low_space_fault = (as_mode == AM_AUTOINC && src_reg == REG_SP) && s >= LOW_SPACE_LIMIT;
                end
                if (as_mode == AM_AUTOINC && src_reg == REG_SP) begin
                    next_cur.sp = cur.sp + next_cur.src_reg_incr;
                end
            end
            if (!keep_flags && set_nz) begin
                next_cur.status[SR_C] = cflag;
                next_cur.status[SR_V] = vflag;
                next_cur.status[SR_Z] = (r & mask) == 20'h00000;
                next_cur.status[SR_N] = (r & msb) != 20'h00000;
            end
            next_cur.result = r;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cur <= '{done: 1'b0, result: 20'h00000, result_write: 1'b0, status: 16'h0000, pc: RESET_PC,
                     sp: RESET_SP, src_reg_incr: 20'h00000, extra_words: 2'h0, push_addr: 20'h00000,
                     low_space_fault: 1'b0};
        end else begin
            cur <= next_cur;
        end
    end

    assign done = cur.done;
    assign result = cur.result;
    assign result_write = cur.result_write;
    assign status = cur.status;
    assign pc = cur.pc;
    assign sp = cur.sp;
    assign src_reg_incr = cur.src_reg_incr;
    assign extra_words = cur.extra_words;
    assign push_addr = cur.push_addr;
    assign low_space_fault = cur.low_space_fault;

    jump_flags_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        exec_valid && is_jump |=> status[3:0] == $past(status[3:0]) && status[SR_V] == $past(status[SR_V]))
        else $error("jump changed flags");
    jump_always_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        exec_valid && is_jump && instr[12:10] == 3'h7 |=>
        pc == $past(pc) + 20'h00002 + {{9{$past(instr[9])}}, $past(instr[9:0]), 1'b0})
        else $error("unconditional jump target wrong");
    jump_zero_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        exec_valid && is_jump && instr[12:10] == 3'h1 && !status[SR_Z] |=> pc == $past(pc) + 20'h00002)
        else $error("zero jump taken with zero clear");
    push_sp_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        exec_valid && is_fmt2 && instr[9:7] == 3'h4 |=> sp == $past(sp) - 20'h00002 && push_addr == sp
        && status == $past(status)) else $error("push stack wrong");
    interrupt_return_sp_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        exec_valid && is_fmt2 && instr[9:7] == 3'h6 |=> sp == $past(sp) + 20'h00004
        && status == $past(stack_top[15:0])) else $error("interrupt return wrong");
    move_flags_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        exec_valid && !is_jump && !is_fmt2 && (instr[15:12] == 4'h4 || instr[15:12] == 4'hc
        || instr[15:12] == 4'hd) |=> status == $past(status)) else $error("flag-neutral op changed flags");
    and_carry_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        exec_valid && !is_jump && !is_fmt2 && instr[15:12] == 4'hf |=> status[SR_C] == !status[SR_Z]
        && !status[SR_V]) else $error("and flags wrong");
    cmp_nowrite_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        exec_valid && !is_jump && !is_fmt2 && (instr[15:12] == 4'h9 || instr[15:12] == 4'hb)
        |=> done && !result_write) else $error("compare wrote result");
    autoinc_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        exec_valid && !is_jump && !is_fmt2 && instr[15:12] >= 4'h4 && instr[5:4] == 2'h3 && instr[11:8] != 4'h0
        && !address_word && instr[6] |=> src_reg_incr == 20'h00001) else $error("byte autoincrement wrong");
endmodule
`default_nettype wire

// ==== dv/stack_memory.sv ====
`default_nettype none
module stack_memory
    import core_exec_pkg::*;
(
    input wire logic [19:0] sp, // Current stack pointer
    output logic [19:0] stack_top, // Word at sp
    output logic [19:0] stack_next // Word at sp plus two
);
    timeunit 1ns;
    timeprecision 1ps;
    // Contents follow the address, so a stale pointer shows a wrong word
    assign stack_top = sp ^ 20'h5a5a5;
    assign stack_next = (sp + STACK_STEP) ^ 20'h5a5a5;
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
`default_nettype none
module tb;
    import core_exec_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'h0, reset_n = 1'h0, exec_valid = 1'h0, address_word = 1'h0;
    logic [15:0] instr = 16'h0000;
    logic [19:0] src_val = 20'h00000, dst_val = 20'h00000;
    logic done, result_write, low_space_fault, c, z, n, v;
    logic [15:0] status;
    logic [1:0] extra_words;
    logic [19:0] result, pc, sp, src_reg_incr, push_addr, stack_top, stack_next, e_pc, e_sp;
    logic [3:0] ops [11] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
    logic [2:0] f2ops [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
    int n_fail = 0, n_compared = 0, seed = 71549;
    always #2.5 ref_clk = ~ref_clk;
    core_instruction_execute i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .exec_valid(exec_valid),
        .instr(instr), .src_val(src_val), .dst_val(dst_val), .stack_top(stack_top), .stack_next(stack_next),
        .address_word(address_word), .done(done), .result(result), .result_write(result_write),
        .status(status), .pc(pc), .sp(sp), .src_reg_incr(src_reg_incr), .extra_words(extra_words),
        .push_addr(push_addr), .low_space_fault(low_space_fault));
    stack_memory i_mem (.sp(sp), .stack_top(stack_top), .stack_next(stack_next));
    task chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task conclude;
        if (n_fail == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task run(input logic [15:0] ins, input logic [19:0] s, input logic [19:0] d);
        logic [19:0] r, m, sv, top, ei;
        logic [7:0] ct;
        logic [4:0] t;
        logic [3:0] op;
        logic [1:0] ew;
        logic cy, vv, wr, fl, inc, flt;
        m = 20'h0ffff;
        ew = 2'h0;
        inc = 1'h0;
        flt = 1'h0;
        r = 20'h00000;
        wr = 1'h1;
        fl = 1'h0;
        cy = c;
        vv = v;
        op = ins[15:12];
        @(posedge ref_clk);
        instr <= ins;
        src_val <= s;
        dst_val <= d;
        exec_valid <= 1'h1;
        @(posedge ref_clk);
        exec_valid <= 1'h0;
        @(negedge ref_clk);
        chk("done", {19'h0, done}, 20'h00001);
        e_pc = e_pc + PC_STEP;
        if (ins[15:13] == JUMP_OPCODE) begin
            wr = 1'h0;
            ct = {1'h1, n ^ v, ~(n ^ v), n, c, ~c, z, ~z};
            if (ct[ins[12:10]]) e_pc = e_pc + {{9{ins[9]}}, ins[9:0], 1'h0};
        end else if (ins[15:10] == FMT2_PREFIX) begin
            ew = 2'(ins[5:4] == AM_INDEXED || (ins[5:4] == AM_AUTOINC && ins[3:0] == REG_PC));
            inc = ins[5:4] == AM_AUTOINC && ins[3:0] != REG_PC;
            case (ins[9:7])
                3'h0: {r, cy, vv, fl} = {4'h0, c, d[15:1], d[0], 2'h1};
                3'h1: r = {4'h0, d[7:0], d[15:8]};
                3'h2: {r, cy, vv, fl} = {4'h0, d[15], d[15:1], d[0], 2'h1};
                3'h3: begin
                    {r, vv, fl} = {{12{d[7]}}, d[7:0], 2'h1};
                    if (ins[5:4] == AM_REG) m = 20'hfffff;
                    else r[19:16] = 4'h0;
                end
                3'h4: begin
                    r = s;
                    e_sp = e_sp - STACK_STEP;
                    chk("push_addr", push_addr, e_sp);
                end
                3'h5: begin
                    m = 20'hfffff;
                    r = e_pc;
                    flt = (e_pc - PC_STEP) >= LOW_SPACE_LIMIT;
                    e_pc = {4'h0, d[15:0]};
                    e_sp = e_sp - STACK_STEP;
                    chk("push_addr", push_addr, e_sp);
                end
                default: begin
                    wr = 1'h0;
                    top = e_sp ^ 20'h5a5a5;
                    {v, n, z, c} = {top[SR_V], top[SR_N], top[SR_Z], top[SR_C]};
                    chk("status", {4'h0, status}, {4'h0, top[15:0]});
                    e_pc = (e_sp + STACK_STEP) ^ 20'h5a5a5;
                    e_sp = e_sp + STACK_STEP + STACK_STEP;
                end
            endcase
            if (ins[9:7] == 3'h3) cy = |r[15:0];
        end else begin
            sv = (op == 4'h7 || op == 4'h8 || op == 4'h9) ? ~s : s;
            fl = !(op == 4'h4 || op == 4'hc || op == 4'hd);
            wr = !(op == 4'h9 || op == 4'hb);
            vv = 1'h0;
            case (op)
                4'h4: r = s;
                4'h5, 4'h6, 4'h7, 4'h8, 4'h9: begin
                    {cy, r[15:0]} = d[15:0] + sv[15:0] + {16'h0, op == 4'h7 || op == 4'h9 || (op != 4'h5 && c)};
                    vv = (sv[15] == d[15]) && (r[15] != d[15]);
                end
                4'ha: for (int i = 0; i < 16; i += 4) begin
                    t = {1'h0, d[i+:4]} + {1'h0, s[i+:4]} + {4'h0, cy};
                    cy = t > 5'h09;
                    r[i+:4] = cy ? 4'(t - 5'h0a) : t[3:0];
                end
                4'hc: r = ~s & d;
                4'hd: r = s | d;
                4'he: {r, vv} = {s ^ d, s[15] & d[15]};
                default: r = s & d;
            endcase
            if (op > 4'ha) cy = |r[15:0];
            ew = 2'(ins[5:4] == AM_INDEXED || (ins[5:4] == AM_AUTOINC && ins[11:8] == REG_PC)) + 2'(ins[AD_BIT]);
            inc = ins[5:4] == AM_AUTOINC && ins[11:8] != REG_PC;
            if (address_word) m = 20'hfffff;
            else if (ins[BW_BIT]) m = 20'h000ff;
        end
        ei = !inc ? 20'h00000 : address_word ? INC_AWORD : ins[BW_BIT] ? INC_BYTE : INC_WORD;
        chk("extra_words", {18'h0, extra_words}, {18'h0, ew});
        chk("src_reg_incr", src_reg_incr, ei);
        chk("result_write", {19'h0, result_write}, {19'h0, wr});
        chk("low_space_fault", {19'h0, low_space_fault}, {19'h0, flt});
        if (fl) {n, z, c, v} = {r[15], r[15:0] == 16'h0, cy, vv};
        if (wr) chk("result", result & m, r & m);
        chk("flags", {16'h0, status[SR_V], status[SR_N], status[SR_Z], status[SR_C]}, {16'h0, v, n, z, c});
        chk("pc", pc, e_pc);
        chk("sp", sp, e_sp);
    endtask
    initial begin
        logic [31:0] s, d, p;
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'h1;
        {c, z, n, v} = 4'h0;
        e_pc = RESET_PC;
        e_sp = RESET_SP;
        run({FMT2_PREFIX, 3'h4, 7'h05}, 20'h00000, 20'h00000);
        run({FMT2_PREFIX, 3'h6, 7'h00}, 20'h00000, 20'h00000);
        repeat (400) begin
            s = $random(seed);
            d = $random(seed);
            p = $random(seed);
            case (p[1:0])
                2'h0: run({JUMP_OPCODE, p[12:10], p[25:16]}, s[19:0], d[19:0]);
                2'h1: run({FMT2_PREFIX, f2ops[p[4:2] % 3'h5], 1'h0, p[15:14], 4'h5}, s[19:0], d[19:0]);
                default: run({ops[p[7:4] % 4'hb], 4'h4, p[8], 1'h0, p[10:9], 4'h5}, s[19:0], d[19:0]);
            endcase
        end
        run({4'ha, 8'h40, 4'h5}, 20'h00001, 20'h09999);
        run({4'ha, 8'h40, 4'h5}, 20'h05678, 20'h01234);
        run({4'h9, 8'h40, 4'h5}, 20'h00000, 20'h08000);
        run({4'h4, 4'h4, 1'h0, 1'h1, 2'h3, 4'h5}, 20'h12345, 20'h00000);
        @(posedge ref_clk);
        address_word <= 1'h1;
        run({4'h4, 4'h4, 1'h0, 1'h0, 2'h3, 4'h5}, 20'h12345, 20'h00000);
        conclude;
    end
    initial begin
        #50000;
        n_fail++;
        conclude;
    end
endmodule
`default_nettype wire
